// ===== common/fls_defs.vh
// Constants for the parallel flash program and erase host controller
// Functional notes
// - Host writes each cycle by pulsing write strobe low under chip select.
// - Host programs only words in already erased sectors, one word a time.
// - Host sends three unlock cycles, then address and data as fourth.
// - Sector erase is six cycles, last is code 30h inside the sector.
// - Block erase is six cycles, last is code 50h inside the block.
// - Host detects end of program or erase by toggle bit 6 alone.
`ifndef FLS_DEFS_VH
`define FLS_DEFS_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define FLS_AW            19
`define FLS_DW            16

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FLS_CLK_NS        5
`define FLS_T_ACC_NS      70
`define FLS_T_WP_NS       40
`define FLS_T_PROG_US     40
`define FLS_T_ERASE_MS    36
`define FLS_ERASE_MARGIN  2
`define FLS_RD_CYC  ((`FLS_T_ACC_NS + `FLS_CLK_NS - 1) / `FLS_CLK_NS)
`define FLS_WP_CYC  ((`FLS_T_WP_NS + `FLS_CLK_NS - 1) / `FLS_CLK_NS)
`define FLS_PROG_CYC  ((`FLS_T_PROG_US * 1000) / `FLS_CLK_NS)
`define FLS_ERASE_CYC \
   ((`FLS_T_ERASE_MS * 1000000 / `FLS_CLK_NS) * `FLS_ERASE_MARGIN)

// ----------------------------------------------------------------
// User operations
// ----------------------------------------------------------------
`define FLS_OP_READ       2'h0
`define FLS_OP_PROG       2'h1
`define FLS_OP_SECT       2'h2
`define FLS_OP_BLOCK      2'h3

// ----------------------------------------------------------------
// Command cycles
// ----------------------------------------------------------------
`define FLS_UNLOCK_A1     19'h05555
`define FLS_UNLOCK_A2     19'h02aaa
`define FLS_CODE_AA       16'h00aa
`define FLS_CODE_55       16'h0055
`define FLS_CODE_PROG     16'h00a0
`define FLS_CODE_ERASE    16'h0080
`define FLS_CODE_SECT     16'h0030
`define FLS_CODE_BLOCK    16'h0050
`define FLS_PROG_LAST     3'h3
`define FLS_ERASE_LAST    3'h5

// ----------------------------------------------------------------
// Address and status fields
// ----------------------------------------------------------------
`define FLS_SECT_LSB      11
`define FLS_BLOCK_LSB     15
`define FLS_TOGGLE_BIT    6
`define FLS_POLL_BIT      7

`endif

// ===== src/fls_bus_cycle.v
// One asynchronous flash bus cycle, read or write, on the flash pins
`timescale 1ns/1ps
`include "fls_defs.vh"

module fls_bus_cycle #(
   parameter AW     = `FLS_AW,
   parameter DW     = `FLS_DW,
   parameter RD_CYC = `FLS_RD_CYC,
   parameter WP_CYC = `FLS_WP_CYC
) (
   input  wire          clock,
   input  wire          srst,
   input  wire          start,
   input  wire          wr,
   input  wire [AW-1:0] addr,
   input  wire [DW-1:0] wdata,
   output reg           done,
   output reg  [DW-1:0] rdata,
   output reg  [AW-1:0] flash_addr,
   output reg           flash_ce_n,
   output reg           flash_oe_n,
   output reg           flash_we_n,
   output reg  [DW-1:0] data_lines_out,
   output reg           data_lines_oe,
   input  wire [DW-1:0] data_lines_in
);

   localparam [1:0] P_IDLE   = 2'h0;
   localparam [1:0] P_SETUP  = 2'h1;
   localparam [1:0] P_STROBE = 2'h2;
   localparam [1:0] P_HOLD   = 2'h3;
   localparam       RD_M1    = RD_CYC - 1;
   localparam       WP_M1    = WP_CYC - 1;
   localparam [7:0] RD_LOAD  = RD_M1[7:0];
   localparam [7:0] WP_LOAD  = WP_M1[7:0];

   reg [1:0] phase_reg;
   reg [7:0] cnt_reg;
   reg       wr_reg;

   always @(posedge clock) begin
      if (srst) begin
         phase_reg      <= P_IDLE;
         cnt_reg        <= 8'h00;
         wr_reg         <= 1'b0;
         done           <= 1'b0;
         rdata          <= {DW{1'b0}};
         flash_addr     <= {AW{1'b0}};
         flash_ce_n     <= 1'b1;
         flash_oe_n     <= 1'b1;
         flash_we_n     <= 1'b1;
         data_lines_out <= {DW{1'b0}};
         data_lines_oe  <= 1'b0;
      end else begin
         done <= 1'b0;
         case (phase_reg)
            P_IDLE: begin
               if (start) begin
                  // Select first so the strobe edge is the later fall
                  flash_addr     <= addr;
                  data_lines_out <= wdata;
                  data_lines_oe  <= wr;
                  wr_reg         <= wr;
                  flash_ce_n     <= 1'b0;
                  phase_reg      <= P_SETUP;
               end
            end
            P_SETUP: begin
               if (wr_reg) begin
                  flash_we_n <= 1'b0;
                  cnt_reg    <= WP_LOAD;
               end else begin
                  flash_oe_n <= 1'b0;
                  cnt_reg    <= RD_LOAD;
               end
               phase_reg <= P_STROBE;
            end
            P_STROBE: begin
               if (cnt_reg == 8'h00) begin
                  // Strobe rises before select: data taken on this edge
                  flash_we_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  if (!wr_reg)
                     rdata <= data_lines_in;
                  phase_reg <= P_HOLD;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            P_HOLD: begin
               // Data held one cycle past the strobe for hold time
               flash_ce_n    <= 1'b1;
               data_lines_oe <= 1'b0;
               done          <= 1'b1;
               phase_reg     <= P_IDLE;
            end
            default: begin
               phase_reg <= P_IDLE;
            end
         endcase
      end
   end

endmodule

// ===== src/fls_flash_host.v
// Host controller driving a parallel flash: read, program, erase
`timescale 1ns/1ps
`include "fls_defs.vh"

module fls_flash_host #(
   parameter AW          = `FLS_AW,
   parameter DW          = `FLS_DW,
   parameter TW          = 26,
   parameter PROG_LIMIT  = `FLS_PROG_CYC,
   parameter ERASE_LIMIT = `FLS_ERASE_CYC
) (
   input  wire          clock,
   input  wire          srst,
   input  wire          cmd_valid,
   input  wire [1:0]    cmd_op,
   input  wire [AW-1:0] cmd_addr,
   input  wire [DW-1:0] cmd_data,
   output reg           cmd_ready,
   output reg           rsp_valid,
   output reg  [DW-1:0] rsp_data,
   output reg           rsp_error,
   output wire [AW-1:0] flash_addr,
   output wire          flash_ce_n,
   output wire          flash_oe_n,
   output wire          flash_we_n,
   output wire [DW-1:0] data_lines_out,
   output wire          data_lines_oe,
   input  wire [DW-1:0] data_lines_in
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_CYC  = 2'h1;
   localparam [1:0] S_POLL = 2'h2;
   localparam [TW-1:0] PROG_LIM  = PROG_LIMIT[TW-1:0];
   localparam [TW-1:0] ERASE_LIM = ERASE_LIMIT[TW-1:0];

   reg [1:0]    state_reg;
   reg [1:0]    op_reg;
   reg [AW-1:0] addr_reg;
   reg [DW-1:0] data_reg;
   reg [2:0]    step_reg;
   reg          start_reg;
   reg          prev_valid_reg;
   reg          prev_tog_reg;
   reg [TW-1:0] timer_reg;

   wire          cyc_done;
   wire [DW-1:0] cyc_rdata;
   wire [AW+DW-1:0] cyc_word;
   wire          cyc_wr;
   wire [2:0]    last_step;
   wire [TW-1:0] limit;

   // ----------------------------------------------------------------
   // Command cycle table
   // ----------------------------------------------------------------
   function [AW+DW-1:0] seq_cycle;
      input [1:0]    op;
      input [2:0]    step;
      input [AW-1:0] a;
      input [DW-1:0] d;
      begin
         case (step)
            3'h0: seq_cycle = {`FLS_UNLOCK_A1, `FLS_CODE_AA};
            3'h1: seq_cycle = {`FLS_UNLOCK_A2, `FLS_CODE_55};
            3'h2: seq_cycle = {`FLS_UNLOCK_A1, (op == `FLS_OP_PROG)
                                 ? `FLS_CODE_PROG : `FLS_CODE_ERASE};
            3'h3: seq_cycle = (op == `FLS_OP_PROG) ? {a, d}
                                 : {`FLS_UNLOCK_A1, `FLS_CODE_AA};
            3'h4: seq_cycle = {`FLS_UNLOCK_A2, `FLS_CODE_55};
            default: seq_cycle = {a, (op == `FLS_OP_SECT)
                                 ? `FLS_CODE_SECT : `FLS_CODE_BLOCK};
         endcase
      end
   endfunction

   // Erase target trimmed to the start of its sector or block
   function [AW-1:0] erase_base;
      input [1:0]    op;
      input [AW-1:0] a;
      begin
         if (op == `FLS_OP_SECT)
            erase_base = (a >> `FLS_SECT_LSB) << `FLS_SECT_LSB;
         else if (op == `FLS_OP_BLOCK)
            erase_base = (a >> `FLS_BLOCK_LSB) << `FLS_BLOCK_LSB;
         else
            erase_base = a;
      end
   endfunction

   // Program and erase share the unlock walk; command code, length and limit differ
   function is_prog;
      input [1:0] op;
      begin
         is_prog = (op == `FLS_OP_PROG);
      end
   endfunction

   // Equal toggle bit on two reads in a row: part is idle again
   function poll_match;
      input          prev_valid;
      input          prev_tog;
      input [DW-1:0] rd;
      begin
         poll_match = prev_valid && (prev_tog == rd[`FLS_TOGGLE_BIT]);
      end
   endfunction

   // Unlock codes fixed, upper data byte zero: no cycle can mismatch
   assign cyc_word = (state_reg == S_CYC && op_reg != `FLS_OP_READ)
                   ? seq_cycle(op_reg, step_reg, addr_reg, data_reg)
                   : {addr_reg, {DW{1'b0}}};
   assign cyc_wr    = (state_reg == S_CYC) && (op_reg != `FLS_OP_READ);
   assign last_step = is_prog(op_reg) ? `FLS_PROG_LAST
                                      : `FLS_ERASE_LAST;
   assign limit     = is_prog(op_reg) ? PROG_LIM
                                      : ERASE_LIM;

   // ----------------------------------------------------------------
   // Pin cycle engine
   // ----------------------------------------------------------------
   fls_bus_cycle #(
      .AW (AW),
      .DW (DW)
   ) u_cycle (
      .clock          (clock),
      .srst           (srst),
      .start          (start_reg),
      .wr             (cyc_wr),
      .addr           (cyc_word[AW+DW-1:DW]),
      .wdata          (cyc_word[DW-1:0]),
      .done           (cyc_done),
      .rdata          (cyc_rdata),
      .flash_addr     (flash_addr),
      .flash_ce_n     (flash_ce_n),
      .flash_oe_n     (flash_oe_n),
      .flash_we_n     (flash_we_n),
      .data_lines_out (data_lines_out),
      .data_lines_oe  (data_lines_oe),
      .data_lines_in  (data_lines_in)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always @(posedge clock) begin
      if (srst) begin
         state_reg      <= S_IDLE;
         op_reg         <= `FLS_OP_READ;
         addr_reg       <= {AW{1'b0}};
         data_reg       <= {DW{1'b0}};
         step_reg       <= 3'h0;
         start_reg      <= 1'b0;
         prev_valid_reg <= 1'b0;
         prev_tog_reg   <= 1'b0;
         timer_reg      <= {TW{1'b0}};
         cmd_ready      <= 1'b0;
         rsp_valid      <= 1'b0;
         rsp_data       <= {DW{1'b0}};
         rsp_error      <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         rsp_valid <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  op_reg    <= cmd_op;
                  addr_reg  <= erase_base(cmd_op, cmd_addr);
                  data_reg  <= cmd_data;
                  step_reg  <= 3'h0;
                  start_reg <= 1'b1;
                  state_reg <= S_CYC;
               end
            end
            S_CYC: begin
               if (cyc_done) begin
                  if (op_reg == `FLS_OP_READ) begin
                     rsp_data  <= cyc_rdata;
                     rsp_error <= 1'b0;
                     rsp_valid <= 1'b1;
                     state_reg <= S_IDLE;
                  end else if (step_reg == last_step) begin
                     // Busy from here: no command cycles until done
                     prev_valid_reg <= 1'b0;
                     timer_reg      <= {TW{1'b0}};
                     start_reg      <= 1'b1;
                     state_reg      <= S_POLL;
                  end else begin
                     step_reg  <= step_reg + 3'h1;
                     start_reg <= 1'b1;
                  end
               end
            end
            S_POLL: begin
               // Saturate so a stuck count never wraps back under the limit
               if (timer_reg != {TW{1'b1}})
                  timer_reg <= timer_reg + {{(TW-1){1'b0}}, 1'b1};
               if (cyc_done) begin
                  if (poll_match(prev_valid_reg, prev_tog_reg,
                                 cyc_rdata)) begin
                     rsp_data  <= cyc_rdata;
                     rsp_error <= 1'b0;
                     rsp_valid <= 1'b1;
                     state_reg <= S_IDLE;
                  end else if (timer_reg >= limit) begin
                     // Bounded wait so a dead part cannot hang us
                     rsp_data  <= cyc_rdata;
                     rsp_error <= 1'b1;
                     rsp_valid <= 1'b1;
                     state_reg <= S_IDLE;
                  end else begin
                     // Status reads only, array data not yet valid
                     prev_tog_reg   <= cyc_rdata[`FLS_TOGGLE_BIT];
                     prev_valid_reg <= 1'b1;
                     start_reg      <= 1'b1;
                  end
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

endmodule

// ===== dv/fls_flash_host_sva.sv
// Checker for the flash host controller pins and command port
`timescale 1ns/1ps
module fls_flash_host_sva #(
   parameter AW = 19,
   parameter DW = 16
) (
   input logic          clock,
   input logic          srst,
   input logic          cmd_valid,
   input logic [1:0]    cmd_op,
   input logic [AW-1:0] cmd_addr,
   input logic [DW-1:0] cmd_data,
   input logic          cmd_ready,
   input logic          rsp_valid,
   input logic [DW-1:0] rsp_data,
   input logic          rsp_error,
   input logic [AW-1:0] flash_addr,
   input logic          flash_ce_n,
   input logic          flash_oe_n,
   input logic          flash_we_n,
   input logic [DW-1:0] data_lines_out,
   input logic          data_lines_oe,
   input logic [DW-1:0] data_lines_in
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // ----------------------------------------
   // Pin discipline
   // ----------------------------------------
   chk_oe_needs_ce: assert property (
      !flash_oe_n |-> !flash_ce_n && !data_lines_oe)
      else $error("output gate low without select or with host driving");
   chk_we_needs_ce: assert property (
      !flash_we_n |-> !flash_ce_n && flash_oe_n)
      else $error("write strobe low outside a selected write");
   chk_we_width: assert property (
      $fell(flash_we_n) |-> !flash_we_n[*8] ##1 flash_we_n)
      else $error("write strobe low time not eight cycles");
   chk_addr_data_hold: assert property (
      !flash_we_n |-> $stable(flash_addr) && $stable(data_lines_out)
         && data_lines_oe)
      else $error("address or data moved under write strobe");
   chk_ce_after_we: assert property (
      $rose(flash_we_n) |-> !flash_ce_n ##1 flash_ce_n)
      else $error("select did not rise one cycle after strobe");
   chk_ce_gap: assert property (
      $rose(flash_ce_n) |-> flash_ce_n[*2])
      else $error("select high less than two cycles");
   chk_read_strobe: assert property (
      $fell(flash_oe_n) |-> !flash_oe_n ##13 !flash_oe_n ##1 flash_oe_n)
      else $error("output gate low time not fourteen cycles");
   // ----------------------------------------
   // Command port
   // ----------------------------------------
   chk_read_latency: assert property (
      cmd_valid && cmd_ready && cmd_op == 2'h0 |-> ##[15:25] rsp_valid)
      else $error("read answer late");
   chk_busy_refuse: assert property (
      cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("ready stayed high after take");
   chk_ready_after: assert property (
      rsp_valid |=> cmd_ready && !rsp_valid)
      else $error("not ready again after answer");
   chk_reset_idle: assert property (
      disable iff (1'b0) srst |=> flash_ce_n && !data_lines_oe && !cmd_ready)
      else $error("pins not idle under reset");
   cov_read: cover property (cmd_valid && cmd_ready && cmd_op == 2'h0);
   cov_prog: cover property (cmd_valid && cmd_ready && cmd_op == 2'h1);
   cov_timeout: cover property (rsp_valid && rsp_error);
endmodule

bind fls_flash_host fls_flash_host_sva #(.AW(AW), .DW(DW)) i_sva (
   .clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
   .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
   .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
   .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
   .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
   .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
   .data_lines_in(data_lines_in));

// ===== dv/fls_flash_model.sv
// Behavioural parallel flash answering the host controller
`timescale 1ns/1ps
module fls_flash_model (
   input  logic [18:0] addr,
   input  logic        ce_n,
   input  logic        oe_n,
   input  logic        we_n,
   input  logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic        dq_oe
);
   bit   [15:0] mem [0:524287];
   logic [18:0] la;
   logic [15:0] pd;
   logic [2:0]  step;
   logic        tog;
   logic        ers;
   int          prog_ns  = 300;
   int          erase_ns = 800;
   time         done_t;
   wire         wr_n = ce_n | we_n;

   initial begin
      foreach (mem[i]) mem[i] = 16'hffff;
      step = 3'h0;
      tog = 1'b0;
      ers = 1'b0;
      pd = 16'h0000;
      done_t = 0;
   end

   function automatic bit busy();
      return $time < done_t;
   endfunction

   function automatic bit m(input logic [18:0] a, input logic [15:0] d,
      input logic [18:0] ea, input logic [7:0] ed);
      return a === ea && d[7:0] === ed;
   endfunction

   task automatic erase(input logic [18:0] a, input int lsb);
      for (int i = 0; i < (1 << lsb); i++)
         mem[((a >> lsb) << lsb) | i] = 16'hffff;
      ers = 1'b1;
      done_t = $time + erase_ns;
   endtask

   // Unlock walk; any mismatch drops back to read mode
   task automatic take(input logic [18:0] a, input logic [15:0] d);
      case (step)
         3'h0, 3'h3:
            step = m(a, d, 19'h05555, 8'haa) ? step + 3'h1 : 3'h0;
         3'h1, 3'h4:
            step = m(a, d, 19'h02aaa, 8'h55) ? step + 3'h1 : 3'h0;
         3'h2: step = m(a, d, 19'h05555, 8'ha0) ? 3'h6
                    : m(a, d, 19'h05555, 8'h80) ? 3'h3 : 3'h0;
         3'h5: begin
            step = 3'h0;
            if (d[7:0] === 8'h30) erase(a, 11);
            else if (d[7:0] === 8'h50) erase(a, 15);
         end
         default: begin
            step = 3'h0;
            mem[a] = mem[a] & d;
            pd = d;
            ers = 1'b0;
            done_t = $time + prog_ns;
         end
      endcase
   endtask

   assign dq_oe = !ce_n && !oe_n;
   always @(negedge wr_n) la = addr;
   // Busy flash drops whole cycles, so no half-taken sequence
   always @(posedge wr_n)
      if (oe_n === 1'b1 && !busy())
         take(la, dq_in);

   always @(negedge oe_n) if (ce_n === 1'b0) begin
      dq_out = mem[addr];
      if (busy()) begin
         dq_out[7] = ers ? 1'b0 : ~pd[7];
         dq_out[6] = tog;
         tog = ~tog;
      end
   end
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module testbench;
   logic        clock;
   logic        srst;
   logic        cmd_valid;
   logic [1:0]  cmd_op;
   logic [18:0] cmd_addr;
   logic [15:0] cmd_data;
   wire         cmd_ready;
   wire         rsp_valid;
   wire  [15:0] rsp_data;
   wire         rsp_error;
   wire  [18:0] fa;
   wire         ce_n;
   wire         oe_n;
   wire         we_n;
   wire  [15:0] dl_out;
   wire         dl_oe;
   wire  [15:0] m_out;
   wire         m_oe;
   wire  [15:0] dq;
   logic [15:0] dq_last;
   logic [15:0] q;
   logic        e;
   int          miscompares;
   int          total_checks;
   int          cyc;

   fls_flash_host #(.PROG_LIMIT(200), .ERASE_LIMIT(400)) i_fls_flash_host (
      .clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
      .flash_addr(fa), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .data_lines_out(dl_out), .data_lines_oe(dl_oe),
      .data_lines_in(dq));
   fls_flash_model i_fls_flash_model (.addr(fa), .ce_n(ce_n), .oe_n(oe_n),
      .we_n(we_n), .dq_in(dq), .dq_out(m_out), .dq_oe(m_oe));

   // Undriven lines show the inverse of their last value, never a hold
   assign dq = dl_oe ? dl_out : m_oe ? m_out : ~dq_last;
   always @(posedge clock) if (dl_oe || m_oe) dq_last <= dq;

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict;
      end
   end

   task automatic check(input logic [15:0] s, input logic [15:0] x);
      total_checks++;
      if (s !== x) begin
         miscompares++;
         $display("Error at %0t: saw %h expected %h", $time, s, x);
      end
   endtask

   task automatic op(input logic [1:0] o, input logic [18:0] a,
      input logic [15:0] d);
      cmd_op = o;
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1'b1;
      // Ready seen settled at a falling edge is taken at the next rise
      while (cmd_ready !== 1'b1) @(negedge clock);
      @(negedge clock);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1) @(negedge clock);
      q = rsp_data;
      e = rsp_error;
      @(negedge clock);
   endtask

   task automatic t_read;
      op(2'h0, 19'h00123, 16'h0000);
      check(q, 16'hffff);
      check({15'h0, e}, 16'h0000);
      $display("read test done");
   endtask

   task automatic t_prog;
      op(2'h1, 19'h12345, 16'h5a3c);
      check(q, 16'h5a3c);
      check({15'h0, e}, 16'h0000);
      op(2'h1, 19'h12346, 16'h00c1);
      check(q, 16'h00c1);
      op(2'h0, 19'h12345, 16'h0000);
      check(q, 16'h5a3c);
      $display("program test done");
   endtask

   task automatic t_erase(input logic [1:0] o, input logic [18:0] at,
      input logic [18:0] lo, input logic [18:0] hi, input logic [18:0] nx);
      op(2'h1, lo, 16'h1111);
      op(2'h1, hi, 16'h2222);
      op(2'h1, nx, 16'h3333);
      op(o, at, 16'h0000);
      check(q, 16'hffff);
      check({15'h0, e}, 16'h0000);
      op(2'h0, lo, 16'h0000);
      check(q, 16'hffff);
      op(2'h0, hi, 16'h0000);
      check(q, 16'hffff);
      op(2'h0, nx, 16'h0000);
      check(q, 16'h3333);
      $display("erase test done");
   endtask

   task automatic t_timeout;
      i_fls_flash_model.erase_ns = 50000;
      op(2'h2, 19'h40000, 16'h0000);
      check({15'h0, e}, 16'h0001);
      $display("timeout test done");
   endtask

   initial begin
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_addr = 19'h00000;
      cmd_data = 16'h0000;
      dq_last = 16'h0000;
      miscompares = 0;
      total_checks = 0;
      cyc = 0;
      repeat (5) @(negedge clock);
      srst = 1'b0;
      t_read;
      t_prog;
      t_erase(2'h2, 19'h00abc, 19'h00800, 19'h00fff, 19'h01000);
      t_erase(2'h3, 19'h0f123, 19'h08000, 19'h0ffff, 19'h10000);
      t_timeout;
      give_verdict;
   end
endmodule
